// ### timer_waveform_output_control.sv
`timescale 1ns/1ps
module timer_waveform_output_control (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [timer_wave_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic compareOutA,
	output logic compareOutB,
	output logic compareEnA,
	output logic compareEnB
);
	import timer_wave_pkg::*;

	ctl_state_t st;
	ctl_state_t next_st;

	logic [7:0] count;
	logic countDown;
	logic [7:0] regIdx;
	logic mapped;
	logic accessDone;
	logic wrStrobe;
	logic wrCount;
	logic [2:0] waveMode;
	wave_class_t waveClass;
	logic [7:0] topValue;
	logic tick;
	logic [PRE_W-1:0] preMask;
	logic atTop;
	logic matchA;
	logic matchB;
	logic ovfEvent;
	logic loadPoint;

	// ---------------------------------------------------------------
	// Helper functions
	// ---------------------------------------------------------------
	function automatic wave_class_t class_of(input logic [2:0] mode);
		case (mode)
			WAVE_NORMAL, WAVE_CTC: class_of = CLASS_NON_PWM;
			WAVE_FAST_MAX, WAVE_FAST_CMPA: class_of = CLASS_FAST;
			WAVE_PC_MAX, WAVE_PC_CMPA: class_of = CLASS_PHASE;
			default: class_of = CLASS_RESERVED;
		endcase
	endfunction : class_of

	// Low bits that must all be one before the prescaler emits a tick
	function automatic logic [PRE_W-1:0] pre_mask(input logic [2:0] sel);
		case (sel)
			CS_DIV1: pre_mask = 10'h000;
			CS_DIV8: pre_mask = 10'h007;
			CS_DIV32: pre_mask = 10'h01f;
			CS_DIV64: pre_mask = 10'h03f;
			CS_DIV128: pre_mask = 10'h07f;
			CS_DIV256: pre_mask = 10'h0ff;
			default: pre_mask = 10'h3ff;
		endcase
	endfunction : pre_mask

	// Next level of one compare output
	function automatic logic wave_next(
		input logic cur,
		input logic [1:0] com,
		input wave_class_t cls,
		input logic chanB,
		input logic waveHigh,
		input logic match,
		input logic wrapBottom,
		input logic down,
		input logic eqTop
	);
		logic res;
		res = cur;
		case (cls)
			CLASS_NON_PWM: begin
				if (match) begin
					case (com)
						COM_TOGGLE: res = ~cur;
						COM_CLEAR: res = 1'b0;
						COM_SET: res = 1'b1;
						default: res = cur;
					endcase
				end
			end
			CLASS_FAST: begin
				if (com == COM_TOGGLE) begin
					// Channel B has no toggle here: its 01 is reserved
					if (!chanB && waveHigh && match) begin
						res = ~cur;
					end
				end else if (com[1]) begin
					if (wrapBottom) begin
						res = (com == COM_CLEAR);
					end
					if (match && !eqTop) begin
						res = (com == COM_SET);
					end
				end
			end
			CLASS_PHASE: begin
				if (com == COM_TOGGLE) begin
					if (!chanB && waveHigh && match) begin
						res = ~cur;
					end
				end else if (com[1] && match) begin
					// At top the match is taken as an up-counting one
					if (eqTop || !down) begin
						res = (com == COM_SET);
					end else begin
						res = (com == COM_CLEAR);
					end
				end
			end
			default: res = cur;
		endcase
		return res;
	endfunction : wave_next

	function automatic logic [31:0] read_word(input ctl_state_t s, input logic [7:0] idx,
		input logic [7:0] cnt);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			// Bits 3:2 have no storage and read as zero
			IDX_CTRL_A: begin
				v[COM_A_LSB +: 2] = s.comA;
				v[COM_B_LSB +: 2] = s.comB;
				v[WAVE_LOW_LSB +: 2] = s.waveLow;
			end
			// Force strobes are not built; their bits read as zero
			IDX_CTRL_B: begin
				v[WAVE_HIGH_BIT] = s.waveHigh;
				v[CLK_SEL_LSB +: 3] = s.clkSel;
			end
			IDX_COUNT: v = cnt;
			IDX_CMP_A: v = s.cmpA;
			IDX_CMP_B: v = s.cmpB;
			IDX_STATUS: begin
				v[STAT_OVF_BIT] = s.ovf;
				v[STAT_MATCH_A_BIT] = s.matchA;
				v[STAT_MATCH_B_BIT] = s.matchB;
			end
			default: v = 8'h00;
		endcase
		return {24'h000000, v};
	endfunction : read_word

	// Whether a channel takes its pin over from the port
	function automatic logic owns_pin(
		input logic [1:0] com,
		input wave_class_t cls,
		input logic chanB,
		input logic waveHigh
	);
		logic own;
		own = (com != COM_OFF);
		// The PWM toggle code of channel A without wave_mode_high leaves the pin to the port;
		// channel B keeps its pin in its reserved code so the level never jumps to the port's
		if (!chanB && com == COM_TOGGLE && !waveHigh
			&& (cls == CLASS_FAST || cls == CLASS_PHASE)) begin
			own = 1'b0;
		end
		return own;
	endfunction : owns_pin

	// Write-one-to-clear request for one status bit
	function automatic logic clear_req(input logic wr, input logic [7:0] idx,
		input logic [31:0] data, input int pos);
		return wr && (idx == IDX_STATUS) && data[pos];
	endfunction : clear_req

	// ---------------------------------------------------------------
	// Address decode and timer context
	// ---------------------------------------------------------------
	assign regIdx = paddr[9:2];
	assign mapped = (paddr[APB_ADDR_W-1:10] == 2'h0) && (paddr[1:0] == 2'h0)
		&& (regIdx >= IDX_CTRL_A) && (regIdx <= IDX_STATUS);
	assign accessDone = psel & penable & st.pready;
	assign wrStrobe = accessDone & pwrite & mapped;
	assign wrCount = wrStrobe & (regIdx == IDX_COUNT);

	assign waveMode = {st.waveHigh, st.waveLow};
	assign waveClass = class_of(waveMode);
	assign topValue = (waveMode == WAVE_CTC || waveMode == WAVE_PC_CMPA
		|| waveMode == WAVE_FAST_CMPA) ? st.actA : TOP_MAX;

	// Stopped clock select gives no ticks at all
	assign preMask = pre_mask(st.clkSel);
	assign tick = (st.clkSel != CS_STOP) && ((st.pre & preMask) == preMask);
	assign atTop = tick && (count == topValue);

	// The tick right after a counter write never matches
	assign matchA = tick && !st.block && (count == st.actA);
	assign matchB = tick && !st.block && (count == st.actB);

	// Fast modes load at the wrap to bottom, phase-correct modes at top
	assign loadPoint = atTop && (waveClass == CLASS_FAST || waveClass == CLASS_PHASE);

	always_comb begin
		case (waveMode)
			WAVE_NORMAL, WAVE_CTC, WAVE_FAST_MAX:
				ovfEvent = tick && (count == TOP_MAX);
			WAVE_FAST_CMPA: ovfEvent = atTop;
			WAVE_PC_MAX, WAVE_PC_CMPA: ovfEvent = tick && countDown && (count == BOTTOM);
			default: ovfEvent = 1'b0;
		endcase
	end

	// Counter writes load the unit directly; a load beats a tick in the same cycle
	timer_count_unit count_unit (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick(tick),
		.phaseCorrect(waveClass == CLASS_PHASE),
		.topValue(topValue),
		.loadEn(wrCount),
		.loadValue(pwdata[7:0]),
		.count(count),
		.countDown(countDown)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		next_st = st;

		// Bus answer is prepared in setup, so access completes with no wait
		if (psel && !penable) begin
			next_st.pready = 1'b1;
			next_st.pslverr = ~mapped;
			next_st.prdata = (mapped && !pwrite) ? read_word(st, regIdx, count) : 32'h00000000;
		end else begin
			next_st.pready = 1'b0;
			next_st.pslverr = 1'b0;
		end

		if (wrStrobe) begin
			case (regIdx)
				IDX_CTRL_A: begin
					next_st.comA = pwdata[COM_A_LSB +: 2];
					next_st.comB = pwdata[COM_B_LSB +: 2];
					next_st.waveLow = pwdata[WAVE_LOW_LSB +: 2];
				end
				IDX_CTRL_B: begin
					next_st.waveHigh = pwdata[WAVE_HIGH_BIT];
					next_st.clkSel = pwdata[CLK_SEL_LSB +: 3];
				end
				IDX_CMP_A: next_st.cmpA = pwdata[7:0];
				IDX_CMP_B: next_st.cmpB = pwdata[7:0];
				default: next_st.cmpA = next_st.cmpA;
			endcase
		end

		// Prescaler restarts while stopped so the first tick is predictable
		next_st.pre = (st.clkSel == CS_STOP) ? '0 : st.pre + 10'h001;

		// Blocking flag: set by a counter write, spent by the next tick
		if (wrCount) begin
			next_st.block = 1'b1;
		end else if (tick) begin
			next_st.block = 1'b0;
		end

		// Compare copies used for matching
		// Unbuffered modes copy a write at once, so a later mode switch starts current
		if (waveClass == CLASS_NON_PWM || waveClass == CLASS_RESERVED) begin
			next_st.actA = next_st.cmpA;
			next_st.actB = next_st.cmpB;
		end else if (loadPoint) begin
			next_st.actA = st.cmpA;
			next_st.actB = st.cmpB;
		end

		// Sticky status; a new event beats a write-one clear in the same cycle
		next_st.ovf = (st.ovf & ~clear_req(wrStrobe, regIdx, pwdata, STAT_OVF_BIT)) | ovfEvent;
		next_st.matchA = (st.matchA & ~clear_req(wrStrobe, regIdx, pwdata, STAT_MATCH_A_BIT))
			| matchA;
		next_st.matchB = (st.matchB & ~clear_req(wrStrobe, regIdx, pwdata, STAT_MATCH_B_BIT))
			| matchB;

		// Waveform outputs
		next_st.outA = wave_next(st.outA, st.comA, waveClass, 1'b0, st.waveHigh, matchA,
			atTop, countDown, st.actA == topValue);
		next_st.outB = wave_next(st.outB, st.comB, waveClass, 1'b1, st.waveHigh, matchB,
			atTop, countDown, st.actB == topValue);

		// Pin takeover follows the compare mode and waveform class; the port keeps the driver
		next_st.enA = owns_pin(next_st.comA, class_of({next_st.waveHigh, next_st.waveLow}),
			1'b0, next_st.waveHigh);
		next_st.enB = owns_pin(next_st.comB, class_of({next_st.waveHigh, next_st.waveLow}),
			1'b1, next_st.waveHigh);
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign compareOutA = st.outA;
	assign compareOutB = st.outB;
	assign compareEnA = st.enA;
	assign compareEnB = st.enB;

endmodule : timer_waveform_output_control

// ### timer_wave_pkg.sv
package timer_wave_pkg;

	// ---------------------------------------------------------------
	// Bus geometry and register indices (byte address = 4 * index)
	// ---------------------------------------------------------------
	localparam int APB_ADDR_W = 12;
	localparam logic [7:0] IDX_CTRL_A = 8'hb0;
	localparam logic [7:0] IDX_CTRL_B = 8'hb1;
	localparam logic [7:0] IDX_COUNT = 8'hb2;
	localparam logic [7:0] IDX_CMP_A = 8'hb3;
	localparam logic [7:0] IDX_CMP_B = 8'hb4;
	localparam logic [7:0] IDX_STATUS = 8'hb5;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int COM_A_LSB = 6;
	localparam int COM_B_LSB = 4;
	localparam int WAVE_LOW_LSB = 0;
	localparam int WAVE_HIGH_BIT = 3;
	localparam int CLK_SEL_LSB = 0;
	localparam int STAT_OVF_BIT = 0;
	localparam int STAT_MATCH_A_BIT = 1;
	localparam int STAT_MATCH_B_BIT = 2;

	// ---------------------------------------------------------------
	// Reset values and counter limits
	// ---------------------------------------------------------------
	localparam logic [7:0] CTRL_A_RESET = 8'h00;
	localparam logic [7:0] CTRL_B_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] CMP_RESET = 8'h00;
	localparam logic [7:0] TOP_MAX = 8'hff;
	localparam logic [7:0] BOTTOM = 8'h00;

	// ---------------------------------------------------------------
	// Waveform modes, compare modes, clock selects
	// ---------------------------------------------------------------
	localparam logic [2:0] WAVE_NORMAL = 3'h0;
	localparam logic [2:0] WAVE_PC_MAX = 3'h1;
	localparam logic [2:0] WAVE_CTC = 3'h2;
	localparam logic [2:0] WAVE_FAST_MAX = 3'h3;
	localparam logic [2:0] WAVE_PC_CMPA = 3'h5;
	localparam logic [2:0] WAVE_FAST_CMPA = 3'h7;

	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;

	localparam int PRE_W = 10;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV32 = 3'h3;
	localparam logic [2:0] CS_DIV64 = 3'h4;
	localparam logic [2:0] CS_DIV128 = 3'h5;
	localparam logic [2:0] CS_DIV256 = 3'h6;

	typedef enum logic [1:0] {CLASS_NON_PWM, CLASS_FAST, CLASS_PHASE, CLASS_RESERVED} wave_class_t;

	typedef struct packed {
		logic [7:0] count;
		logic down;
	} count_state_t;

	typedef struct packed {
		logic [1:0] comA;
		logic [1:0] comB;
		logic [1:0] waveLow;
		logic waveHigh;
		logic [2:0] clkSel;
		logic [7:0] cmpA;
		logic [7:0] cmpB;
		logic [7:0] actA;
		logic [7:0] actB;
		logic [PRE_W-1:0] pre;
		logic block;
		logic ovf;
		logic matchA;
		logic matchB;
		logic outA;
		logic outB;
		logic enA;
		logic enB;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ctl_state_t;

endpackage : timer_wave_pkg

// ### timer_count_unit.sv
`timescale 1ns/1ps
module timer_count_unit (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic tick,
	input wire logic phaseCorrect,
	input wire logic [7:0] topValue,
	input wire logic loadEn,
	input wire logic [7:0] loadValue,
	output logic [7:0] count,
	output logic countDown
);
	import timer_wave_pkg::*;

	count_state_t st;
	count_state_t next_st;

	// ---------------------------------------------------------------
	// Counting sequence
	// ---------------------------------------------------------------
	always_comb begin
		next_st = st;
		if (loadEn) begin
			// Software write wins over a tick in the same cycle
			next_st.count = loadValue;
		end else if (tick) begin
			if (phaseCorrect) begin
				if (!st.down && st.count >= topValue) begin
					next_st.down = 1'b1;
					next_st.count = (topValue == BOTTOM) ? BOTTOM : st.count - 8'h01;
				end else if (st.down && st.count == BOTTOM) begin
					next_st.down = 1'b0;
					next_st.count = (topValue == BOTTOM) ? BOTTOM : 8'h01;
				end else if (st.down) begin
					next_st.count = st.count - 8'h01;
				end else begin
					next_st.count = st.count + 8'h01;
				end
			end else begin
				next_st.down = 1'b0;
				// Wrap at top; a top lowered below the count still wraps at MAX
				next_st.count = (st.count == topValue) ? BOTTOM : st.count + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign count = st.count;
	assign countDown = st.down;

endmodule : timer_count_unit

// ### timer_wave_monitor.sv
`timescale 1ns/1ps
module timer_wave_monitor (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [timer_wave_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic compareEnA,
	input wire logic compareEnB
);
	import timer_wave_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [1:0] comA;
	logic [1:0] comB;
	logic [1:0] waveLow;
	logic waveHigh;
	logic ownA;
	logic rdDone;
	assign rdDone = pready && !pwrite;
	// Shadow of the compare modes, so pin ownership is judged from bus traffic only
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			comA <= 2'h0;
			comB <= 2'h0;
			waveLow <= 2'h0;
			waveHigh <= 1'b0;
		end else if (pready && pwrite && !pslverr && paddr[9:2] == IDX_CTRL_A) begin
			comA <= pwdata[7:6];
			comB <= pwdata[5:4];
			waveLow <= pwdata[1:0];
		end else if (pready && pwrite && !pslverr && paddr[9:2] == IDX_CTRL_B) begin
			waveHigh <= pwdata[3];
		end
	end
	// Channel A toggle code in a PWM mode keeps the pin only with wave_mode_high set
	assign ownA = (comA != COM_OFF) && !(comA == COM_TOGGLE && !waveHigh && waveLow[0]);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable && pready;
	endsequence
	a_ready_after_setup: assert property (setup_s |=> access_s)
		else $error("no ready after setup");
	a_ready_single: assert property (access_s |=> !pready)
		else $error("ready longer than one cycle");
	a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without ready or with data");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_ctla_reserved: assert property (
		rdDone && paddr[9:2] == IDX_CTRL_A |-> prdata[3:2] == 2'h0)
		else $error("control a reserved bits set");
	a_ctlb_reserved: assert property (
		rdDone && paddr[9:2] == IDX_CTRL_B |-> prdata[7:4] == 4'h0)
		else $error("control b upper bits set");
	a_owner_a: assert property (
		$stable({comA, waveLow, waveHigh}) |-> compareEnA == ownA)
		else $error("pin a ownership wrong");
	a_owner_b: assert property ($stable(comB) |-> compareEnB == (comB != COM_OFF))
		else $error("pin b ownership wrong");
endmodule : timer_wave_monitor

bind timer_waveform_output_control timer_wave_monitor mon (.clk(clk), .sys_rst(sys_rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .compareEnA(compareEnA),
	.compareEnB(compareEnB));

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import timer_wave_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [APB_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic compareOutA;
	logic compareOutB;
	logic compareEnA;
	logic compareEnB;
	int mismatches = 0;
	int comparisons = 0;
	logic [31:0] q;
	logic e;
	logic o;
	int n;

	always #50 clk = ~clk;

	timer_waveform_output_control dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .compareOutA(compareOutA),
		.compareOutB(compareOutB), .compareEnA(compareEnA), .compareEnB(compareEnB));

	// ---------------------------------------------------------------
	// Bus and measurement helpers
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		// Waits as long as the slave stalls; only the watchdog ends a hung transfer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, i, d);
	endtask : wr

	task automatic rd(input logic [7:0] i, input logic [7:0] x, input string nm);
		apb(1'b0, i, 8'h00);
		chk(nm, {24'h0, x}, q);
	endtask : rd

	function automatic logic pin(input bit b);
		return b ? compareOutB : compareOutA;
	endfunction : pin

	// Length of the next complete run of the chosen level; partial runs are skipped
	task automatic runlen(input bit b, input logic lvl, output int c);
		int g;
		g = 0;
		c = 0;
		while (pin(b) === lvl && g < 2000) begin @(posedge clk); g++; end
		while (pin(b) !== lvl && g < 2000) begin @(posedge clk); g++; end
		while (pin(b) === lvl && c < 2000) begin @(posedge clk); c++; end
	endtask : runlen

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs;
		for (int i = 0; i < 6; i++) rd(IDX_CTRL_A + 8'(i), 8'h00, "reset value");
		chk("owner reset", 32'h0, {30'h0, compareEnA, compareEnB});
		wr(IDX_CTRL_A, 8'h0c);
		rd(IDX_CTRL_A, 8'h00, "ctl a reserved");
		wr(IDX_CTRL_B, 8'hf8);
		rd(IDX_CTRL_B, 8'h08, "ctl b high bit");
		apb(1'b1, 8'hb6, 8'h55);
		chk("unmapped err", 32'h1, {31'h0, e});
		wr(IDX_CTRL_B, 8'h00);
	endtask : t_regs

	task automatic t_nonpwm;
		wr(IDX_CMP_A, 8'h10);
		wr(IDX_CMP_B, 8'h20);
		wr(IDX_CTRL_A, 8'hf0);
		wr(IDX_CTRL_B, 8'h01);
		repeat (300) @(posedge clk);
		chk("set on match", 32'h3, {30'h0, compareOutA, compareOutB});
		chk("owner on", 32'h3, {30'h0, compareEnA, compareEnB});
		rd(IDX_STATUS, 8'h07, "flags");
		wr(IDX_CTRL_A, 8'ha0);
		repeat (300) @(posedge clk);
		chk("clear on match", 32'h0, {30'h0, compareOutA, compareOutB});
		wr(IDX_CTRL_A, 8'h50);
		runlen(1'b0, 1'b1, n);
		chk("toggle a", 256, n);
		runlen(1'b1, 1'b0, n);
		chk("toggle b", 256, n);
		wr(IDX_CMP_A, 8'h3f);
		wr(IDX_CTRL_A, 8'h42);
		repeat (300) @(posedge clk);
		runlen(1'b0, 1'b1, n);
		chk("ctc toggle", 64, n);
	endtask : t_nonpwm

	task automatic t_fast;
		wr(IDX_CMP_A, 8'h40);
		wr(IDX_CMP_B, 8'h40);
		wr(IDX_CTRL_A, 8'ha3);
		repeat (600) @(posedge clk);
		runlen(1'b0, 1'b1, n);
		chk("fast high a", 65, n);
		runlen(1'b1, 1'b1, n);
		chk("fast high b", 65, n);
		wr(IDX_CTRL_A, 8'hf3);
		runlen(1'b0, 1'b0, n);
		chk("fast low a", 65, n);
		runlen(1'b1, 1'b0, n);
		chk("fast low b", 65, n);
		wr(IDX_CMP_A, 8'hff);
		repeat (600) @(posedge clk);
		n = 0;
		repeat (300) begin
			@(posedge clk);
			if (compareOutA !== 1'b0) n++;
		end
		chk("top compare", 0, n);
		wr(IDX_CMP_A, 8'h3f);
		wr(IDX_CTRL_A, 8'h43);
		wr(IDX_CTRL_B, 8'h09);
		repeat (600) @(posedge clk);
		runlen(1'b0, 1'b1, n);
		chk("top toggle", 64, n);
		chk("owner toggle", 32'h1, {31'h0, compareEnA});
		wr(IDX_CTRL_B, 8'h01);
		repeat (5) @(posedge clk);
		o = compareOutA;
		n = 0;
		repeat (300) begin
			@(posedge clk);
			if (compareOutA !== o) n++;
		end
		chk("toggle off", 0, n);
		chk("owner released", 32'h0, {31'h0, compareEnA});
	endtask : t_fast

	task automatic t_phase;
		wr(IDX_CMP_A, 8'h40);
		wr(IDX_CMP_B, 8'h40);
		wr(IDX_CTRL_A, 8'ha1);
		repeat (1200) @(posedge clk);
		runlen(1'b0, 1'b0, n);
		chk("phase low a", 382, n);
		runlen(1'b1, 1'b0, n);
		chk("phase low b", 382, n);
	endtask : t_phase

	task automatic t_block;
		wr(IDX_CTRL_B, 8'h00);
		wr(IDX_CTRL_A, 8'h40);
		wr(IDX_CMP_A, 8'h10);
		wr(IDX_COUNT, 8'h10);
		wr(IDX_STATUS, 8'h07);
		o = compareOutA;
		wr(IDX_CTRL_B, 8'h01);
		repeat (10) @(posedge clk);
		chk("blocked pin", {31'h0, o}, {31'h0, compareOutA});
		rd(IDX_STATUS, 8'h00, "blocked flag");
	endtask : t_block

	task automatic tally_and_finish;
		if (mismatches == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs;
		t_nonpwm;
		t_fast;
		t_phase;
		t_block;
		tally_and_finish;
	end

	// Full run needs well under half of this span
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		tally_and_finish;
	end
endmodule : tb_top
